// >>> core/wicr_top.sv
`timescale 1ns/100ps
// Operation
// - global bit clear: interrupt on wake only; set: on every status event.
// - measurement select forces inputs one and two out of wake sources.
// - measurement clear by default; inputs one, two follow their enables.
// - measurement runs in normal mode; levels of inputs one, two invalid.
// - enable bits 2..0 make inputs three..one wake sources.
// - reserved bits are read-only and read zero.
// - bus wake is not enabled here, only by bus control mode.
// - fail-safe entry forces sources to x0x0 0111 and requests bus wake mode.
// - source register resets to 0000 0111; restart applies x0x0 0xxx.
// - two-bit pull field per input: none, down, up, automatic.
// - filter 00 is static sensing with a 16 us filter.
// - filter 01 is static sensing with a 64 us filter.
// - filter 10 samples at end of first cyclic on-time, 16 us filter.
// - filter 11 samples at end of second cyclic on-time, 16 us filter.
module wicr_top
    import wicr_pkg::*;
#(
    parameter int N_WAKE = 3
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire wicr_pkg::wicr_reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    input wire wicr_pkg::wicr_mode_t MODE,
    input wire logic [N_WAKE-1:0] WAKE_PIN,
    input wire logic CYC_A_ON_END,
    input wire logic CYC_B_ON_END,
    input wire logic OTHER_STATUS_EVT,
    input wire logic [N_WAKE-1:0] WAKE_FLAG_CLR,
    output logic [N_WAKE-1:0] WAKE_FLAG,
    output logic [N_WAKE-1:0] WAKE_LEVEL,
    output logic [N_WAKE-1:0] LEVEL_VALID,
    output logic [N_WAKE-1:0] PULL_UP_EN,
    output logic [N_WAKE-1:0] PULL_DN_EN,
    output logic MEAS_ACTIVE,
    output logic BUS_WAKE_FORCE,
    output logic INT_OUT
);
    import wicr_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [7:0] src_r;
    logic [7:0] src_nxt;
    logic [7:0] pull_r;
    logic [7:0] pull_nxt;
    logic [7:0] filt_r;
    logic [7:0] filt_nxt;
    logic [N_WAKE-1:0] pin_s;
    logic [N_WAKE-1:0] lvl;
    logic [N_WAKE-1:0] chg;
    logic [N_WAKE-1:0] src_en;
    logic [N_WAKE-1:0] wake_evt;
    logic [7:0] rd_nxt;
    logic meas_sel;
    logic glob_sel;
    logic any_wake;
    logic [N_WAKE-1:0] lvl_ok;

    // masked write: only writable bits take data, reserved bits stay zero
    function automatic logic [7:0] wr_val(input logic [7:0] d, input logic [7:0] m);
        wr_val = d & m;
    endfunction

    // restart keeps the masked bits and clears the rest
    function automatic logic [7:0] keep_val(input logic [7:0] q, input logic [7:0] m);
        keep_val = q & m;
    endfunction

    function automatic logic is_wr(input wicr_reg_req_t r, input logic [6:0] a);
        is_wr = r.wr & (r.addr == a);
    endfunction

    // ****************************************************************
    // wake source control
    // ****************************************************************
    // priority: soft reset, then fail-safe, then restart, then software
    always_comb begin
        src_nxt = src_r;
        if (MODE.soft_reset) begin
            src_nxt = WICR_RST_SRC;
        end else if (MODE.fail_safe) begin
            src_nxt = (src_r & WICR_FS_KEEP_SRC) | WICR_FS_VAL_SRC;
        end else if (MODE.restart) begin
            src_nxt = keep_val(src_r, WICR_KEEP_SRC);
        end else if (is_wr(REG_REQ, WICR_ADDR_SRC)) begin
            src_nxt = wr_val(REG_REQ.wdata, WICR_WMASK_SRC);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            src_r <= WICR_RST_SRC;
        end else begin
            src_r <= src_nxt;
        end
    end

    // ****************************************************************
    // pull and filter control
    // ****************************************************************
    // fail-safe leaves these alone
    always_comb begin
        pull_nxt = pull_r;
        if (MODE.soft_reset) begin
            pull_nxt = WICR_RST_PULL;
        end else if (MODE.restart) begin
            pull_nxt = keep_val(pull_r, WICR_KEEP_PULL);
        end else if (is_wr(REG_REQ, WICR_ADDR_PULL)) begin
            pull_nxt = wr_val(REG_REQ.wdata, WICR_WMASK_PULL);
        end
    end

    always_comb begin
        filt_nxt = filt_r;
        if (MODE.soft_reset) begin
            filt_nxt = WICR_RST_FILT;
        end else if (MODE.restart) begin
            filt_nxt = keep_val(filt_r, WICR_KEEP_FILT);
        end else if (is_wr(REG_REQ, WICR_ADDR_FILT)) begin
            // a cyclic choice only works once its timer drives a switch
            filt_nxt = wr_val(REG_REQ.wdata, WICR_WMASK_FILT);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pull_r <= WICR_RST_PULL;
            filt_r <= WICR_RST_FILT;
        end else begin
            pull_r <= pull_nxt;
            filt_r <= filt_nxt;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // data is registered, so a read answers one cycle after its address
    always_comb begin
        unique case (REG_REQ.addr)
            WICR_ADDR_SRC: rd_nxt = src_r;
            WICR_ADDR_PULL: rd_nxt = pull_r;
            WICR_ADDR_FILT: rd_nxt = filt_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= rd_nxt;
        end
    end

    // ****************************************************************
    // wake inputs
    // ****************************************************************
    // pins are asynchronous: two flops stand before any logic reads them
    wicr_sync #(
        .W(N_WAKE)
    ) u_sync (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .d(WAKE_PIN),
        .q(pin_s)
    );

    // cyclic timer pulses come from logic on this clock: no synchroniser
    generate
        for (genvar i = 0; i < N_WAKE; i++) begin : g_in
            wicr_filter u_filt (
                .clk(CLK_SYS),
                .rst_n(RST_N),
                .raw(pin_s[i]),
                .mode(wicr_flt_t'(filt_r[2*i +: 2])),
                .cyc_a_end(CYC_A_ON_END),
                .cyc_b_end(CYC_B_ON_END),
                .level(lvl[i]),
                .changed(chg[i])
            );
        end
    endgenerate

    assign meas_sel = src_r[WICR_POS_MEAS];
    assign glob_sel = src_r[WICR_POS_GLOBAL];

    // only pin inputs are combined here; bus wake lives in bus control
    generate
        for (genvar i = 0; i < N_WAKE; i++) begin : g_en
            if (i < 2) begin : g_meas
                assign src_en[i] = src_r[WICR_POS_EN + i] & ~meas_sel;
            end else begin : g_plain
                assign src_en[i] = src_r[WICR_POS_EN + i];
            end
        end
    endgenerate

    assign wake_evt = chg & src_en;
    assign any_wake = |wake_evt;

    // ****************************************************************
    // level validity
    // ****************************************************************
    // inputs one and two serve the measurement when selected, so their levels mean nothing
    generate
        for (genvar i = 0; i < N_WAKE; i++) begin : g_valid
            if (i < 2) begin : g_meas
                assign lvl_ok[i] = ~meas_sel;
            end else begin : g_plain
                assign lvl_ok[i] = 1'b1;
            end
        end
    endgenerate

    // ****************************************************************
    // wake flags
    // ****************************************************************
    // a new event beats a clear in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            WAKE_FLAG <= '0;
        end else begin
            WAKE_FLAG <= (WAKE_FLAG & ~WAKE_FLAG_CLR) | wake_evt;
        end
    end

    // ****************************************************************
    // interrupt
    // ****************************************************************
    // wake events always interrupt; other status only when the global bit is set
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            INT_OUT <= 1'b0;
        end else begin
            INT_OUT <= any_wake | (glob_sel & OTHER_STATUS_EVT);
        end
    end

    // ****************************************************************
    // levels, measurement and pulls
    // ****************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            WAKE_LEVEL <= '0;
            LEVEL_VALID <= '0;
            MEAS_ACTIVE <= 1'b0;
        end else begin
            // validity travels with the level so both change on one edge
            WAKE_LEVEL <= lvl;
            LEVEL_VALID <= lvl_ok;
            MEAS_ACTIVE <= meas_sel & MODE.normal_mode;
        end
    end

    // automatic pull follows the accepted level to hold it
    generate
        for (genvar i = 0; i < N_WAKE; i++) begin : g_pull
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    PULL_UP_EN[i] <= 1'b0;
                    PULL_DN_EN[i] <= 1'b0;
                end else begin
                    unique case (wicr_pull_t'(pull_r[2*i +: 2]))
                        WICR_PULL_NONE: begin
                            PULL_UP_EN[i] <= 1'b0;
                            PULL_DN_EN[i] <= 1'b0;
                        end
                        WICR_PULL_DOWN: begin
                            PULL_UP_EN[i] <= 1'b0;
                            PULL_DN_EN[i] <= 1'b1;
                        end
                        WICR_PULL_UP: begin
                            PULL_UP_EN[i] <= 1'b1;
                            PULL_DN_EN[i] <= 1'b0;
                        end
                        WICR_PULL_AUTO: begin
                            PULL_UP_EN[i] <= lvl[i];
                            PULL_DN_EN[i] <= ~lvl[i];
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************************************
    // bus wake request on fail-safe
    // ****************************************************************
    // bus control sits elsewhere; it loads xxx0 0001 on this pulse
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            BUS_WAKE_FORCE <= 1'b0;
        end else begin
            BUS_WAKE_FORCE <= MODE.fail_safe & ~MODE.soft_reset;
        end
    end
endmodule

// >>> inc/wicr_pkg.sv
// ****************************************************************
// constants and carriers
// ****************************************************************
package wicr_pkg;

    // register indices (7-bit register address)
    localparam logic [6:0] WICR_ADDR_SRC = 7'h07;
    localparam logic [6:0] WICR_ADDR_PULL = 7'h08;
    localparam logic [6:0] WICR_ADDR_FILT = 7'h09;

    // reset values
    localparam logic [7:0] WICR_RST_SRC = 8'h07;
    localparam logic [7:0] WICR_RST_PULL = 8'h00;
    localparam logic [7:0] WICR_RST_FILT = 8'h00;

    // writable bits; everything else reads zero
    localparam logic [7:0] WICR_WMASK_SRC = 8'ha7;
    localparam logic [7:0] WICR_WMASK_PULL = 8'h3f;
    localparam logic [7:0] WICR_WMASK_FILT = 8'h3f;

    // restart: set bits of the keep mask hold their value, the rest clear
    localparam logic [7:0] WICR_KEEP_SRC = 8'ha7;
    localparam logic [7:0] WICR_KEEP_PULL = 8'h3f;
    localparam logic [7:0] WICR_KEEP_FILT = 8'h3f;

    // fail-safe: keep bits 7 and 5, force the low five bits to 0 0111
    localparam logic [7:0] WICR_FS_KEEP_SRC = 8'ha0;
    localparam logic [7:0] WICR_FS_VAL_SRC = 8'h07;

    // field positions of the source control register
    localparam int WICR_POS_GLOBAL = 7;
    localparam int WICR_POS_MEAS = 5;
    localparam int WICR_POS_EN = 0;

    // timing
    localparam int WICR_CLK_HZ = 20000000;
    localparam int WICR_FILT_SHORT_US = 16;
    localparam int WICR_FILT_LONG_US = 64;
    localparam int WICR_CNT_W = 11;
    localparam logic [WICR_CNT_W-1:0] WICR_FILT_SHORT_CYC =
        WICR_CNT_W'((WICR_FILT_SHORT_US * WICR_CLK_HZ + 999999) / 1000000);
    localparam logic [WICR_CNT_W-1:0] WICR_FILT_LONG_CYC =
        WICR_CNT_W'((WICR_FILT_LONG_US * WICR_CLK_HZ + 999999) / 1000000);

    typedef enum logic [1:0] {
        WICR_FLT_STATIC_SHORT = 2'b00,
        WICR_FLT_STATIC_LONG = 2'b01,
        WICR_FLT_CYCLIC_A = 2'b10,
        WICR_FLT_CYCLIC_B = 2'b11
    } wicr_flt_t;

    typedef enum logic [1:0] {
        WICR_PULL_NONE = 2'b00,
        WICR_PULL_DOWN = 2'b01,
        WICR_PULL_UP = 2'b10,
        WICR_PULL_AUTO = 2'b11
    } wicr_pull_t;

    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic [7:0] wdata;
    } wicr_reg_req_t;

    typedef struct packed {
        logic soft_reset;
        logic restart;
        logic fail_safe;
        logic normal_mode;
    } wicr_mode_t;

endpackage

// >>> core/wicr_sync.sv
`timescale 1ns/100ps
// ****************************************************************
// two-flop synchroniser
// ****************************************************************
module wicr_sync #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// >>> core/wicr_filter.sv
`timescale 1ns/100ps
// ****************************************************************
// one wake input: stability counter and level acceptance
// ****************************************************************
module wicr_filter
    import wicr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    input wire wicr_pkg::wicr_flt_t mode,
    input wire logic cyc_a_end,
    input wire logic cyc_b_end,
    output logic level,
    output logic changed
);
    logic raw_d_r;
    logic [WICR_CNT_W-1:0] stable_r;
    logic [WICR_CNT_W-1:0] stable_nxt;
    logic short_ok;
    logic long_ok;
    logic accept;

    // stable_r counts cycles that raw has held its current value
    always_comb begin
        if (raw != raw_d_r) begin
            stable_nxt = '0;
        end else if (stable_r != '1) begin
            stable_nxt = stable_r + WICR_CNT_W'(1);
        end else begin
            stable_nxt = stable_r;
        end
    end

    assign short_ok = (stable_nxt >= WICR_FILT_SHORT_CYC);
    assign long_ok = (stable_nxt >= WICR_FILT_LONG_CYC);

    always_comb begin
        unique case (mode)
            WICR_FLT_STATIC_SHORT: accept = short_ok;
            WICR_FLT_STATIC_LONG: accept = long_ok;
            // cyclic: only the sample at the end of the on-time counts
            WICR_FLT_CYCLIC_A: accept = cyc_a_end & short_ok;
            WICR_FLT_CYCLIC_B: accept = cyc_b_end & short_ok;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            raw_d_r <= 1'b0;
            stable_r <= '0;
        end else begin
            raw_d_r <= raw;
            stable_r <= stable_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level <= 1'b0;
            changed <= 1'b0;
        end else begin
            changed <= accept & (raw != level);
            if (accept) begin
                level <= raw;
            end
        end
    end
endmodule

// >>> tb/wicr_top_assertions.sv
`timescale 1ns/100ps
// ****************************************************************
// port checker for the wake control registers
// ****************************************************************
module wicr_top_chk
    import wicr_pkg::*;
#(
    parameter int N_WAKE = 3
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire wicr_pkg::wicr_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire wicr_pkg::wicr_mode_t MODE,
    input wire logic [N_WAKE-1:0] WAKE_PIN,
    input wire logic OTHER_STATUS_EVT,
    input wire logic [N_WAKE-1:0] WAKE_FLAG_CLR,
    input wire logic [N_WAKE-1:0] WAKE_FLAG,
    input wire logic [N_WAKE-1:0] WAKE_LEVEL,
    input wire logic [N_WAKE-1:0] LEVEL_VALID,
    input wire logic [N_WAKE-1:0] PULL_UP_EN,
    input wire logic [N_WAKE-1:0] PULL_DN_EN,
    input wire logic MEAS_ACTIVE,
    input wire logic BUS_WAKE_FORCE,
    input wire logic INT_OUT
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    rdata_resv_a: assert property ($past(REG_REQ.addr) == WICR_ADDR_SRC |->
        (REG_RDATA & 8'h58) == 8'h00) else $error("reserved source bits read nonzero");
    rdata_unmap_a: assert property ($past(REG_REQ.addr) < 7'h07 ||
        $past(REG_REQ.addr) > 7'h09 |-> REG_RDATA == 8'h00) else $error("unmapped read nonzero");
    fs_force_a: assert property (MODE.fail_safe && !MODE.soft_reset |=> BUS_WAKE_FORCE)
        else $error("fail-safe entry gave no bus wake request");
    bus_wake_a: assert property (BUS_WAKE_FORCE |-> $past(MODE.fail_safe) &&
        !$past(MODE.soft_reset)) else $error("bus wake request without fail-safe entry");
    meas_valid_a: assert property (MEAS_ACTIVE |-> LEVEL_VALID[1:0] == 2'b00)
        else $error("levels one and two valid during measurement");
    pull_excl_a: assert property ((PULL_UP_EN & PULL_DN_EN) == '0)
        else $error("pull-up and pull-down both on");
    flag_int_a: assert property (|(WAKE_FLAG & ~$past(WAKE_FLAG)) |-> INT_OUT)
        else $error("new wake flag without interrupt");
    int_cause_a: assert property (INT_OUT |-> $past(OTHER_STATUS_EVT) || WAKE_FLAG != '0)
        else $error("interrupt without cause");
    flag_level_a: assert property ((WAKE_FLAG & ~$past(WAKE_FLAG) &
        ~(WAKE_LEVEL ^ $past(WAKE_LEVEL))) == '0) else $error("wake flag without level change");
    level_pin_a: assert property (((WAKE_LEVEL ^ $past(WAKE_LEVEL)) &
        (WAKE_LEVEL ^ $past(WAKE_PIN, 8))) == '0) else $error("level taken from unstable pin");
    flag_hold_a: assert property (($past(WAKE_FLAG) & ~$past(WAKE_FLAG_CLR) & ~WAKE_FLAG) == '0)
        else $error("wake flag lost without clear");
endmodule

bind wicr_top wicr_top_chk #(.N_WAKE(N_WAKE)) u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .MODE(MODE), .WAKE_PIN(WAKE_PIN),
    .OTHER_STATUS_EVT(OTHER_STATUS_EVT), .WAKE_FLAG_CLR(WAKE_FLAG_CLR), .WAKE_FLAG(WAKE_FLAG),
    .WAKE_LEVEL(WAKE_LEVEL), .LEVEL_VALID(LEVEL_VALID), .PULL_UP_EN(PULL_UP_EN),
    .PULL_DN_EN(PULL_DN_EN), .MEAS_ACTIVE(MEAS_ACTIVE), .BUS_WAKE_FORCE(BUS_WAKE_FORCE),
    .INT_OUT(INT_OUT));

// >>> tb/wicr_pin_model.sv
`timescale 1ns/100ps
// ****************************************************************
// external switches on the wake pins
// ****************************************************************
module wicr_pin_model (
    input wire logic [2:0] lvl,
    input wire logic [2:0] glitch,
    output logic [2:0] pin
);
    // a glitch flips a closed or open switch briefly, as contact bounce would
    assign pin = lvl ^ glitch;
endmodule

// >>> tb/wicr_tb_top.sv
`timescale 1ns/100ps
// ****************************************************************
// testbench
// ****************************************************************
module wicr_tb_top;
    import wicr_pkg::*;
    typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} wicr_row_t;
    logic clk = 1'b0, rst_n = 1'b0, cyc_a = 1'b0, cyc_b = 1'b0, oth = 1'b0, meas, bwf, irq;
    logic [2:0] lvl = '0, glt = '0, clr = '0, pins, flag, level, valid, pu, pd;
    logic [7:0] rdata;
    wicr_reg_req_t req = '0;
    wicr_mode_t mode = '0;
    int n_errors = 0, num_checks = 0, cycles = 0, n;
    wicr_row_t rows [9] = '{'{7'h07, 8'hff, 8'ha7}, '{7'h07, 8'h00, 8'h00},
        '{7'h08, 8'hff, 8'h3f}, '{7'h09, 8'hff, 8'h3f}, '{7'h0a, 8'hff, 8'h00},
        '{7'h06, 8'hff, 8'h00}, '{7'h09, 8'h00, 8'h00}, '{7'h08, 8'h00, 8'h00},
        '{7'h07, 8'h07, 8'h07}};

    always #25 clk = ~clk;
    // ceiling well above the roughly 4000 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    wicr_top #(.N_WAKE(3)) dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
        .MODE(mode), .WAKE_PIN(pins), .CYC_A_ON_END(cyc_a), .CYC_B_ON_END(cyc_b),
        .OTHER_STATUS_EVT(oth), .WAKE_FLAG_CLR(clr), .WAKE_FLAG(flag), .WAKE_LEVEL(level),
        .LEVEL_VALID(valid), .PULL_UP_EN(pu), .PULL_DN_EN(pd), .MEAS_ACTIVE(meas),
        .BUS_WAKE_FORCE(bwf), .INT_OUT(irq));
    wicr_pin_model u_pins (.lvl(lvl), .glitch(glt), .pin(pins));

    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        req = '{a, 1'b1, d};
        tick(1);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        req.addr = a;
        tick(2);
        chk(rdata, e);
    endtask
    task automatic wait_lvl(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (level[i] !== v && k < lim) begin
            tick(1);
            k++;
        end
    endtask
    task automatic clear_flags();
        clr = 3'b111;
        tick(1);
        clr = 3'b000;
    endtask
    task automatic pulse_cyc(input logic b);
        if (b) cyc_b = 1'b1; else cyc_a = 1'b1;
        tick(1);
        cyc_a = 1'b0;
        cyc_b = 1'b0;
        tick(3);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #2 rst_n = 1'b1;
        rd(WICR_ADDR_SRC, 8'h07);
        rd(WICR_ADDR_PULL, 8'h00);
        rd(WICR_ADDR_FILT, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // auto pull follows the filtered level, which is low here
        wr(WICR_ADDR_PULL, 8'h1b);
        tick(1);
        chk({5'h0, pu}, 8'h02);
        chk({5'h0, pd}, 8'h05);
        wr(WICR_ADDR_SRC, 8'ha0);
        mode.soft_reset = 1'b1;
        tick(1);
        mode.soft_reset = 1'b0;
        rd(WICR_ADDR_SRC, 8'h07);
        rd(WICR_ADDR_PULL, 8'h00);
        wr(WICR_ADDR_SRC, 8'ha7);
        mode.restart = 1'b1;
        tick(1);
        mode.restart = 1'b0;
        rd(WICR_ADDR_SRC, 8'ha7);
        wr(WICR_ADDR_SRC, 8'ha0);
        mode.fail_safe = 1'b1;
        tick(1);
        mode.fail_safe = 1'b0;
        chk({7'h0, bwf}, 8'h01);
        rd(WICR_ADDR_SRC, 8'ha7);
        oth = 1'b1;
        tick(1);
        oth = 1'b0;
        chk({7'h0, irq}, 8'h01);
        wr(WICR_ADDR_SRC, 8'h07);
        oth = 1'b1;
        tick(1);
        oth = 1'b0;
        chk({7'h0, irq}, 8'h00);
        lvl[0] = 1'b1;
        wait_lvl(0, 1'b1, 2000, n);
        chk({7'h0, n >= 320 && n <= 340}, 8'h01);
        chk({6'h0, flag[0], irq}, 8'h03);
        clear_flags();
        wr(WICR_ADDR_FILT, 8'h04);
        lvl[1] = 1'b1;
        wait_lvl(1, 1'b1, 2000, n);
        chk({7'h0, n >= 1280 && n <= 1300}, 8'h01);
        clear_flags();
        glt[2] = 1'b1;
        tick(100);
        glt[2] = 1'b0;
        tick(400);
        chk({5'h0, level}, 8'h03);
        wr(WICR_ADDR_SRC, 8'h03);
        lvl[2] = 1'b1;
        wait_lvl(2, 1'b1, 500, n);
        chk({6'h0, level[2], flag[2]}, 8'h02);
        wr(WICR_ADDR_SRC, 8'h27);
        mode.normal_mode = 1'b1;
        tick(2);
        chk({4'h0, meas, valid}, 8'h0c);
        lvl[0] = 1'b0;
        wait_lvl(0, 1'b0, 500, n);
        chk({6'h0, level[0], flag[0]}, 8'h00);
        wr(WICR_ADDR_SRC, 8'h07);
        mode.normal_mode = 1'b0;
        lvl[0] = 1'b1;
        wait_lvl(0, 1'b1, 500, n);
        chk({7'h0, flag[0]}, 8'h01);
        clear_flags();
        // cyclic timer a is assumed assigned to a high-side switch by software
        wr(WICR_ADDR_FILT, 8'h20);
        lvl[2] = 1'b0;
        tick(400);
        pulse_cyc(1'b1);
        chk({7'h0, level[2]}, 8'h01);
        pulse_cyc(1'b0);
        chk({6'h0, level[2], flag[2]}, 8'h01);
        wr(WICR_ADDR_FILT, 8'h30);
        lvl[2] = 1'b1;
        tick(400);
        pulse_cyc(1'b0);
        chk({7'h0, level[2]}, 8'h00);
        pulse_cyc(1'b1);
        chk({7'h0, level[2]}, 8'h01);
        tally_and_finish();
    end
endmodule
